// file: rtl/fmrb_pkg.sv
// constants of the fan monitor register bank: commands, fields, resets, timing
// assumes a 100 MHz core clock and a host-driven serial clock well below it
package fmrb_pkg;
   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_SPEED     = 8'h00;
   localparam logic [7:0] CMD_THRESHOLD = 8'h02;
   localparam logic [7:0] CMD_CONTROL   = 8'h04;
   localparam logic [7:0] CMD_FLAGS     = 8'h05;
   localparam logic [7:0] CMD_SETTING   = 8'h06;
   localparam logic [7:0] CMD_MAKER     = 8'h07;
   localparam logic [7:0] CMD_VARIANT   = 8'h08;
   localparam int         NUM_REGS      = 7;
   // ------------------------------------------------------------
   // link constants
   // ------------------------------------------------------------
   localparam logic [6:0] SLAVE_ADDR = 7'h1b;
   localparam logic       BIT_ACK    = 1'b0;
   localparam logic       BIT_NACK   = 1'b1;
   localparam logic       DIR_WRITE  = 1'b0;
   localparam logic       DIR_READ   = 1'b1;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTL_FAULT_CLEAR = 7;
   localparam int CTL_STEP_SELECT = 6;
   localparam int CTL_DUTY_SOURCE = 5;
   localparam int CTL_PPT_HI      = 2;
   localparam int CTL_PPT_LO      = 1;
   localparam int CTL_LOW_POWER   = 0;
   localparam int FLG_OVERFLOW    = 3;
   localparam int FLG_FAULT       = 0;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [8:0] SPEED_RESET     = 9'h000;
   localparam logic [7:0] THRESHOLD_RESET = 8'h0a;
   localparam logic [7:0] CONTROL_RESET   = 8'h0a;
   localparam logic [7:0] SETTING_RESET   = 8'h02;
   // arbitrary neutral identity values
   localparam logic [7:0] MAKER_VALUE     = 8'h5a;
   localparam logic [1:0] VARIANT_VALUE   = 2'h1;
   // ------------------------------------------------------------
   // speed arithmetic and timing
   // ------------------------------------------------------------
   localparam int          FINE_RPM_STEP   = 25;
   localparam int          MAX_SPEED_CODE  = 511;
   localparam int          CLK_MHZ         = 100;
   localparam int          FAULT_TIME_MS   = 2400;
   localparam int          FAULT_CYCLES    = FAULT_TIME_MS * 1000 * CLK_MHZ;
   localparam int          WINDOW_TIME_MS  = 1000;
   localparam int          WINDOW_CYCLES   = WINDOW_TIME_MS * 1000 * CLK_MHZ;
   // pulses per minute = pulses per second * 60, one code step is 25 rpm
   localparam int          RPM_PER_HZ      = 60;
endpackage : fmrb_pkg

// file: rtl/fmrb_sync.sv
// two-flop synchroniser for one pin level
// assumes the input is asynchronous to core_clk
module fmrb_sync
   import fmrb_pkg::*;
#(
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic pinIn,
   output logic      pinSync
);
   logic stage1Reg;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1Reg <= RESET_LEVEL;
         pinSync   <= RESET_LEVEL;
      end else begin
         stage1Reg <= pinIn;
         pinSync   <= stage1Reg;
      end
   end
endmodule : fmrb_sync

// file: rtl/fmrb_speed_meter.sv
// counts sensed pulses over a gate window and turns them into a speed code
// assumes pulseSeen is a one-cycle pulse on core_clk
module fmrb_speed_meter
   import fmrb_pkg::*;
#(
   parameter int WINDOW = WINDOW_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       pulseSeen,
   input  wire logic [1:0] pulsesPerTurn,
   input  wire logic       fineStep,
   output logic [8:0]      speedCode,
   output logic            speedOverflow,
   output logic            speedValid
);
   logic [31:0] gateReg;
   logic [23:0] pulseCountReg;
   logic [31:0] rpmFine;
   logic [31:0] codeFull;

   // rpm/25 = pulses_per_s * 60 / ppt / 25; window is one second
   always_comb begin
      rpmFine  = (32'(pulseCountReg) * 32'(RPM_PER_HZ)) >> pulsesPerTurn;
      codeFull = rpmFine / 32'(FINE_RPM_STEP);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gateReg       <= '0;
         pulseCountReg <= '0;
         speedCode     <= SPEED_RESET;
         speedOverflow <= 1'b0;
         speedValid    <= 1'b0;
      end else begin
         speedValid <= 1'b0;
         if (gateReg >= 32'(WINDOW - 1)) begin
            gateReg       <= '0;
            pulseCountReg <= 24'(pulseSeen);
            speedValid    <= 1'b1;
            speedOverflow <= codeFull > 32'(MAX_SPEED_CODE);
            if (codeFull > 32'(MAX_SPEED_CODE)) begin
               speedCode <= 9'h1ff;
            end else if (fineStep) begin
               speedCode <= codeFull[8:0];
            end else begin
               speedCode <= {codeFull[8:1], 1'b0};
            end
         end else begin
            gateReg       <= gateReg + 32'h1;
            pulseCountReg <= pulseCountReg + 24'(pulseSeen);
         end
      end
   end
endmodule : fmrb_speed_meter

// file: rtl/fmrb_bank.sv
// fan monitor register bank: serial slave, seven registers, fault timer
// assumes sclk/sda come from a slow host with pull-ups; sense is a digital pulse
// ------------------------------------------------------------
// Operation
// - ack is 0, read direction is 1
// - exactly seven registers exposed
// - command byte picks the register
// - codes 00, 02, 04 select speed/threshold/control
// - 05 flags read-only, 06 setting resets 02
// - 07 maker code, 08 variant code
// - 9-bit speed, 25 or 50 rpm steps
// - control bit 6 picks step, reset 0
// - overflow flag bit 3 from 12800 rpm
// - threshold 8 bits, 50 rpm steps
// - threshold resets to 0a
// - below threshold 2.4 s sets fault
// - control register resets to 0a
// - control holds step, source, ppt, stop; clear bit 7 is not stored
// - source bit picks analog or register duty
// - ppt field 1,2,4,8 pulses per turn
// - receive byte reads last selected register
// - ack only own address after start
// ------------------------------------------------------------
module fmrb_bank
   import fmrb_pkg::*;
#(
   parameter int FAULT_TIME = FAULT_CYCLES,
   parameter int WINDOW     = WINDOW_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       sclkIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOutEn_n,
   input  wire logic       senseIn,
   input  wire logic [3:0] analogDuty,
   output logic [3:0]      dutyOut,
   output logic            faultOut_n,
   output logic            lowPowerStop
);
   // ------------------------------------------------------------
   // synchronisers and edges
   // ------------------------------------------------------------
   logic sclkSync, sdaSync, senseSync;
   logic sclkLast, sdaLast, senseLast;
   logic sclkRise, sclkFall, startSeen, stopSeen, senseRise;

   fmrb_sync #(.RESET_LEVEL(1'b1)) uSclk (
      .core_clk(core_clk), .sys_rst(sys_rst), .pinIn(sclkIn), .pinSync(sclkSync));
   fmrb_sync #(.RESET_LEVEL(1'b1)) uSda (
      .core_clk(core_clk), .sys_rst(sys_rst), .pinIn(sdaIn), .pinSync(sdaSync));
   fmrb_sync #(.RESET_LEVEL(1'b0)) uSense (
      .core_clk(core_clk), .sys_rst(sys_rst), .pinIn(senseIn), .pinSync(senseSync));

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclkLast  <= 1'b1;
         sdaLast   <= 1'b1;
         senseLast <= 1'b0;
      end else begin
         sclkLast  <= sclkSync;
         sdaLast   <= sdaSync;
         senseLast <= senseSync;
      end
   end

   assign sclkRise  = sclkSync & ~sclkLast;
   assign sclkFall  = ~sclkSync & sclkLast;
   assign startSeen = sclkSync & sclkLast & sdaLast & ~sdaSync;
   assign stopSeen  = sclkSync & sclkLast & ~sdaLast & sdaSync;
   assign senseRise = senseSync & ~senseLast;

   // ------------------------------------------------------------
   // serial slave state machine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FMRB_IDLE     = 3'b000,
      FMRB_ADDR     = 3'b001,
      FMRB_ADDR_ACK = 3'b010,
      FMRB_RX       = 3'b011,
      FMRB_RX_ACK   = 3'b100,
      FMRB_TX       = 3'b101,
      FMRB_TX_ACK   = 3'b110
   } fmrb_state_t;

   fmrb_state_t stateReg;
   logic [7:0]  shiftReg;
   logic [3:0]  bitCountReg;
   logic        readDirReg;
   logic        haveCmdReg;
   logic [7:0]  cmdReg;
   logic        ackDriveReg;
   logic        txDriveReg;
   logic        wrStrobe;
   logic [7:0]  wrData;
   logic [7:0]  readData;

   // registers
   logic [7:0] thresholdReg, controlReg, settingReg;
   logic [8:0] speedCode;
   logic       speedOverflow;
   logic       faultFlagReg;
   logic       faultClear;
   logic [31:0] lowTimeReg;

   // unknown commands read as zero; seven mapped codes only
   always_comb begin
      case (cmdReg)
         CMD_SPEED:     readData = controlReg[CTL_STEP_SELECT] ? speedCode[7:0]
                                                               : speedCode[8:1];
         CMD_THRESHOLD: readData = thresholdReg;
         CMD_CONTROL:   readData = controlReg;
         CMD_FLAGS:     readData = {4'h0, speedOverflow, 2'h0, faultFlagReg};
         CMD_SETTING:   readData = settingReg;
         CMD_MAKER:     readData = MAKER_VALUE;
         CMD_VARIANT:   readData = {6'h00, VARIANT_VALUE};
         default:       readData = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stateReg    <= FMRB_IDLE;
         shiftReg    <= '0;
         bitCountReg <= '0;
         readDirReg  <= 1'b0;
         haveCmdReg  <= 1'b0;
         cmdReg      <= CMD_SPEED;
         ackDriveReg <= 1'b0;
         txDriveReg  <= 1'b0;
         wrStrobe    <= 1'b0;
         wrData      <= '0;
      end else begin
         wrStrobe <= 1'b0;
         if (startSeen) begin
            stateReg    <= FMRB_ADDR;
            bitCountReg <= '0;
            ackDriveReg <= 1'b0;
            txDriveReg  <= 1'b0;
         end else if (stopSeen) begin
            stateReg    <= FMRB_IDLE;
            ackDriveReg <= 1'b0;
            txDriveReg  <= 1'b0;
         end else begin
            case (stateReg)
               FMRB_IDLE: begin
               end
               FMRB_ADDR, FMRB_RX: begin
                  if (sclkRise) begin
                     shiftReg    <= {shiftReg[6:0], sdaSync};
                     bitCountReg <= bitCountReg + 4'h1;
                  end else if (sclkFall && bitCountReg == 4'h8) begin
                     bitCountReg <= '0;
                     if (stateReg == FMRB_ADDR) begin
                        if (shiftReg[7:1] == SLAVE_ADDR) begin
                           readDirReg  <= shiftReg[0] == DIR_READ;
                           haveCmdReg  <= 1'b0;
                           ackDriveReg <= 1'b1;
                           stateReg    <= FMRB_ADDR_ACK;
                        end else begin
                           stateReg <= FMRB_IDLE;
                        end
                     end else begin
                        ackDriveReg <= 1'b1;
                        stateReg    <= FMRB_RX_ACK;
                        if (!haveCmdReg) begin
                           cmdReg     <= shiftReg;
                           haveCmdReg <= 1'b1;
                        end else begin
                           wrStrobe <= 1'b1;
                           wrData   <= shiftReg;
                        end
                     end
                  end
               end
               FMRB_ADDR_ACK, FMRB_RX_ACK: begin
                  if (sclkFall) begin
                     ackDriveReg <= 1'b0;
                     if (readDirReg) begin
                        // receive byte uses whatever command was kept
                        shiftReg   <= readData;
                        txDriveReg <= 1'b1;
                        stateReg   <= FMRB_TX;
                     end else begin
                        stateReg <= FMRB_RX;
                     end
                  end
               end
               FMRB_TX: begin
                  if (sclkFall) begin
                     if (bitCountReg == 4'h7) begin
                        bitCountReg <= '0;
                        txDriveReg  <= 1'b0;
                        stateReg    <= FMRB_TX_ACK;
                     end else begin
                        shiftReg    <= {shiftReg[6:0], 1'b0};
                        bitCountReg <= bitCountReg + 4'h1;
                     end
                  end
               end
               FMRB_TX_ACK: begin
                  if (sclkRise) begin
                     if (sdaSync == BIT_NACK) begin
                        stateReg <= FMRB_IDLE;
                     end
                  end else if (sclkFall) begin
                     shiftReg   <= readData;
                     txDriveReg <= 1'b1;
                     stateReg   <= FMRB_TX;
                  end
               end
               default: stateReg <= FMRB_IDLE;
            endcase
         end
      end
   end

   // open drain: enable low means driving a zero
   always_comb begin
      sdaOut     = 1'b0;
      sdaOutEn_n = ~((ackDriveReg & (BIT_ACK == 1'b0)) | (txDriveReg & ~shiftReg[7]));
   end

   // ------------------------------------------------------------
   // writable registers
   // ------------------------------------------------------------
   assign faultClear = wrStrobe && cmdReg == CMD_CONTROL && wrData[CTL_FAULT_CLEAR];

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         thresholdReg <= THRESHOLD_RESET;
         controlReg   <= CONTROL_RESET;
         settingReg   <= SETTING_RESET;
      end else begin
         if (wrStrobe) begin
            case (cmdReg)
               CMD_THRESHOLD: thresholdReg <= wrData;
               // clear bit is self-resetting, not stored
               CMD_CONTROL:   controlReg <= {1'b0, wrData[6:0]};
               CMD_SETTING:   settingReg <= wrData;
               default: begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // speed measurement and fault timer
   // ------------------------------------------------------------
   fmrb_speed_meter #(.WINDOW(WINDOW)) uMeter (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .pulseSeen     (senseRise),
      .pulsesPerTurn (controlReg[CTL_PPT_HI:CTL_PPT_LO]),
      .fineStep      (controlReg[CTL_STEP_SELECT]),
      .speedCode     (speedCode),
      .speedOverflow (speedOverflow),
      .speedValid    ()
   );

   // threshold is in 50 rpm steps, speed code in 25 rpm steps
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lowTimeReg   <= '0;
         faultFlagReg <= 1'b0;
      end else begin
         if (speedCode < {thresholdReg, 1'b0}) begin
            if (lowTimeReg < 32'(FAULT_TIME)) begin
               lowTimeReg <= lowTimeReg + 32'h1;
            end
         end else begin
            lowTimeReg <= '0;
         end
         // set wins over a clear in the same cycle
         if (lowTimeReg >= 32'(FAULT_TIME)) begin
            faultFlagReg <= 1'b1;
         end else if (faultClear) begin
            faultFlagReg <= 1'b0;
         end
         if (faultClear && lowTimeReg >= 32'(FAULT_TIME)) begin
            lowTimeReg <= '0;
         end
      end
   end

   assign faultOut_n   = ~faultFlagReg;
   assign lowPowerStop = controlReg[CTL_LOW_POWER];

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dutyOut <= SETTING_RESET[3:0];
      end else begin
         dutyOut <= controlReg[CTL_DUTY_SOURCE] ? settingReg[3:0] : analogDuty;
      end
   end
endmodule : fmrb_bank

// file: sim/fmrb_bank_asserts.sv
// pin-level checker for the fan monitor register bank
// assumes a host serial clock far slower than core_clk
module fmrb_bank_asserts
   import fmrb_pkg::*;
#(
   parameter int FAULT_TIME = FAULT_CYCLES
) (
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic       sclkIn,
   input wire logic       sdaOut,
   input wire logic       sdaOutEn_n,
   input wire logic [3:0] analogDuty,
   input wire logic [3:0] dutyOut,
   input wire logic       faultOut_n,
   input wire logic       lowPowerStop
);
   timeunit 1ns;
   timeprecision 100ps;
   int   upCnt;
   logic seenLink;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // saturating, so a long run cannot wrap it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) upCnt <= 0;
      else if (upCnt < FAULT_TIME) upCnt <= upCnt + 1;
   end
   // no control write can land before the first link activity
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) seenLink <= 1'b0;
      else if (!sclkIn) seenLink <= 1'b1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence ackHeld;
      !sdaOutEn_n [*4];
   endsequence
   sequence idleFault;
      (!faultOut_n && sclkIn) [*4];
   endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_sda_only_low: assert property (sdaOut == 1'b0)
      else $error("data pin driven high");
   a_pull_moves_low: assert property ($changed(sdaOutEn_n) |-> !sclkIn)
      else $error("data pull changed while clock high");
   a_ack_held_high: assert property ($rose(sclkIn) && !sdaOutEn_n |-> ackHeld)
      else $error("data pull dropped during clock high");
   a_fault_not_early: assert property ($fell(faultOut_n) |-> upCnt >= FAULT_TIME - 2)
      else $error("fault raised before the fault time");
   a_fault_clear_link: assert property ($rose(faultOut_n) |-> !sclkIn)
      else $error("fault cleared outside a host write");
   a_fault_holds_idle: assert property (idleFault |=> !faultOut_n)
      else $error("fault dropped while link idle");
   a_stop_via_write: assert property ($changed(lowPowerStop) |-> !sclkIn)
      else $error("stop control changed outside a write");
   a_duty_from_pin: assert property (!seenLink |=> dutyOut == $past(analogDuty))
      else $error("duty not following analog input");
   a_reset_outputs: assert property (disable iff (1'b0) sys_rst |-> faultOut_n && sdaOutEn_n && !lowPowerStop)
      else $error("outputs not idle in reset");
endmodule : fmrb_bank_asserts

bind fmrb_bank fmrb_bank_asserts #(.FAULT_TIME(FAULT_TIME)) chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .sclkIn(sclkIn), .sdaOut(sdaOut),
   .sdaOutEn_n(sdaOutEn_n), .analogDuty(analogDuty), .dutyOut(dutyOut),
   .faultOut_n(faultOut_n), .lowPowerStop(lowPowerStop));

// file: sim/fmrb_host.sv
// serial bus master model for the bank's clock and data pins
// assumes the bench resolves the pulled-up data wire from all pulls
module fmrb_host
   import fmrb_pkg::*;
(
   output logic      sclk,
   output logic      sdaLow,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   real q        = 31.25;
   real lowExtra = 0.0;
   // clock stands high and data is released between frames
   initial begin
      sclk   = 1'b1;
      sdaLow = 1'b0;
   end
   // data moves only while the clock is low
   task automatic bitIo(input logic b, output logic seen);
      #(q + lowExtra) sdaLow = !b;
      #q sclk = 1'b1;
      seen = sda;
      #(2.0 * q) sclk = 1'b0;
   endtask : bitIo
   task automatic start;
      if (!sclk) begin
         #q sdaLow = 1'b0;
         #q sclk = 1'b1;
      end
      #q sdaLow = 1'b1;
      #q sclk = 1'b0;
   endtask : start
   task automatic stop;
      #q sdaLow = 1'b1;
      #q sclk = 1'b1;
      #q sdaLow = 1'b0;
      #q;
   endtask : stop
   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitIo(b[i], s);
      bitIo(1'b1, ack);
   endtask : sendByte
   task automatic recvByte(input logic ackBit, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bitIo(1'b1, b[i]);
      bitIo(ackBit, s);
   endtask : recvByte
   task automatic writeReg(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] d,
                           output logic [2:0] acks);
      start();
      sendByte({adr, DIR_WRITE}, acks[2]);
      sendByte(cmd, acks[1]);
      sendByte(d, acks[0]);
      stop();
   endtask : writeReg
   task automatic readReg(input logic [7:0] cmd, output logic [7:0] d, output logic [2:0] acks);
      start();
      sendByte({SLAVE_ADDR, DIR_WRITE}, acks[2]);
      sendByte(cmd, acks[1]);
      start();
      sendByte({SLAVE_ADDR, DIR_READ}, acks[0]);
      recvByte(BIT_NACK, d);
      stop();
   endtask : readReg
   // no command byte: the device answers from its last selection
   task automatic recvOnly(output logic [7:0] d, output logic ack);
      start();
      sendByte({SLAVE_ADDR, DIR_READ}, ack);
      recvByte(BIT_NACK, d);
      stop();
   endtask : recvOnly
endmodule : fmrb_host

// file: sim/tb_fan_monitor_register_bank.sv
// self-checking bench for the fan monitor register bank
// assumes fmrb_host as bus master; fault time and gate window shortened
module tb_fan_monitor_register_bank
   import fmrb_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int FT  = 8000;
   localparam int WIN = 1000;
   logic       core_clk   = 1'b0;
   logic       sys_rst    = 1'b0;
   logic       senseIn    = 1'b0;
   logic [3:0] analogDuty = 4'h5;
   logic       sclk, hostLow, sdaOut, sdaOutEn_n, faultOut_n, lowPowerStop;
   logic [3:0] dutyOut;
   wire        sdaWire    = !(hostLow || (!sdaOutEn_n && !sdaOut));
   int         senseDiv   = 20;
   int         senseCnt   = 0;
   int         errCount   = 0;
   int         samplesChecked = 0;
   initial forever #5 core_clk = !core_clk;
   // one sense pulse every senseDiv cycles: a window holds an exact count
   always @(posedge core_clk) begin
      senseCnt <= (senseCnt + 1 >= senseDiv) ? 0 : senseCnt + 1;
      senseIn  <= (senseCnt == 0);
   end
   fmrb_bank #(.FAULT_TIME(FT), .WINDOW(WIN)) uut (
      .core_clk(core_clk), .sys_rst(sys_rst), .sclkIn(sclk), .sdaIn(sdaWire), .sdaOut(sdaOut),
      .sdaOutEn_n(sdaOutEn_n), .senseIn(senseIn), .analogDuty(analogDuty),
      .dutyOut(dutyOut), .faultOut_n(faultOut_n), .lowPowerStop(lowPowerStop));
   fmrb_host host (.sclk(sclk), .sdaLow(hostLow), .sda(sdaWire));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      logic [7:0] d;
      logic [2:0] a;
      host.readReg(cmd, d, a);
      chk({5'h0, a}, 8'h00);
      chk(d, exp);
   endtask : rd
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
      logic [2:0] a;
      host.writeReg(SLAVE_ADDR, cmd, d, a);
      chk({5'h0, a}, 8'h00);
   endtask : wr
   task automatic endSim;
      $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : endSim
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic tReset;
      logic [7:0] cmds [8] = '{CMD_SPEED, CMD_FLAGS, CMD_THRESHOLD, CMD_CONTROL,
                               CMD_SETTING, CMD_MAKER, CMD_VARIANT, 8'h03};
      logic [7:0] exps [8] = '{8'h00, 8'h00, THRESHOLD_RESET, CONTROL_RESET,
                               SETTING_RESET, MAKER_VALUE, {6'h0, VARIANT_VALUE}, 8'h00};
      chk({7'h0, faultOut_n}, 8'h01);
      chk({7'h0, lowPowerStop}, 8'h00);
      chk({4'h0, dutyOut}, 8'h05);
      for (int i = 0; i < 8; i++) rd(cmds[i], exps[i]);
      $display("reset values done");
   endtask : tReset
   task automatic tAccess;
      logic [7:0] d;
      logic       a;
      wr(CMD_THRESHOLD, 8'hff);
      rd(CMD_THRESHOLD, 8'hff);
      host.lowExtra = 250.0;
      host.recvOnly(d, a);
      host.lowExtra = 0.0;
      chk({a, d[6:0]} ^ {1'b0, d[6:0]}, 8'h00);
      chk(d, 8'hff);
      wr(CMD_THRESHOLD, THRESHOLD_RESET);
      wr(CMD_FLAGS, 8'hff);
      rd(CMD_FLAGS, 8'h00);
      wr(CMD_MAKER, 8'h00);
      rd(CMD_MAKER, MAKER_VALUE);
      wr(CMD_SETTING, 8'h0f);
      rd(CMD_SETTING, 8'h0f);
      $display("access done");
   endtask : tAccess
   task automatic tDuty;
      @(posedge core_clk) analogDuty <= 4'h3;
      repeat (3) @(posedge core_clk);
      chk({4'h0, dutyOut}, 8'h03);
      wr(CMD_CONTROL, 8'h2a);
      chk({4'h0, dutyOut}, 8'h0f);
      wr(CMD_CONTROL, 8'h0b);
      chk({4'h0, dutyOut}, 8'h03);
      chk({7'h0, lowPowerStop}, 8'h01);
      wr(CMD_CONTROL, CONTROL_RESET);
      chk({7'h0, lowPowerStop}, 8'h00);
      $display("duty done");
   endtask : tDuty
   task automatic tSpeed;
      for (int p = 0; p < 4; p++) begin
         wr(CMD_CONTROL, 8'h40 | 8'(p << 1));
         repeat (2 * WIN + 500) @(posedge core_clk);
         rd(CMD_SPEED, 8'd120 >> p);
      end
      wr(CMD_CONTROL, 8'h02);
      repeat (2 * WIN + 500) @(posedge core_clk);
      rd(CMD_SPEED, 8'd30);
      $display("speed done");
   endtask : tSpeed
   task automatic tOverflow;
      wr(CMD_CONTROL, 8'h40);
      senseDiv = 4;
      repeat (2 * WIN + 500) @(posedge core_clk);
      rd(CMD_SPEED, 8'hff);
      rd(CMD_FLAGS, 8'h08);
      senseDiv = 20;
      repeat (2 * WIN + 500) @(posedge core_clk);
      rd(CMD_FLAGS, 8'h00);
      $display("overflow done");
   endtask : tOverflow
   task automatic tFault;
      wr(CMD_THRESHOLD, 8'hff);
      repeat (FT - 1000) @(posedge core_clk);
      chk({7'h0, faultOut_n}, 8'h01);
      repeat (2000) @(posedge core_clk);
      chk({7'h0, faultOut_n}, 8'h00);
      rd(CMD_FLAGS, 8'h01);
      wr(CMD_THRESHOLD, THRESHOLD_RESET);
      repeat (2 * WIN) @(posedge core_clk);
      chk({7'h0, faultOut_n}, 8'h00);
      rd(CMD_FLAGS, 8'h01);
      wr(CMD_CONTROL, 8'hc0);
      chk({7'h0, faultOut_n}, 8'h01);
      rd(CMD_FLAGS, 8'h00);
      rd(CMD_CONTROL, 8'h40);
      $display("fault done");
   endtask : tFault
   task automatic tAddress;
      logic [2:0] a;
      host.writeReg(SLAVE_ADDR ^ 7'h01, CMD_THRESHOLD, 8'h55, a);
      chk({5'h0, a}, 8'h07);
      rd(CMD_THRESHOLD, THRESHOLD_RESET);
      $display("address done");
   endtask : tAddress
   initial begin
      // a real edge at time zero, so the asynchronous reset acts at once
      sys_rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      tReset();
      tAccess();
      tDuty();
      tSpeed();
      tOverflow();
      tFault();
      tAddress();
      endSim();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      errCount++;
      $display("unexpected at %0t: run hung, got %h expected %h", $time, 1'b0, 1'b1);
      endSim();
   end
endmodule : tb_fan_monitor_register_bank
